/* File: ems_strobes.sv */
// ems_strobes: address latch strobe, program fetch strobe, data strobes and
// multiplexed address/data byte of the external memory bus.
// assumes the core drives its side synchronously on i_mclk; pins are synchronised.
//
// Summary of operation
// - address latch strobe once per machine cycle, none in power-down
// - low address present when latch strobe falls
// - port 0 carries low address then data
// - two program fetch strobes per external cycle
// - data move skips both fetch strobes
// - fetch strobe high in power-down
// - quiet bit stops latch strobe toggling outside bus cycles
// - quiet bit resets zero, software writable
// - quiet mode holds latch strobe low in internal cycles
// - data moves still toggle latch strobe
// - quiet: high in idle, low in power-down
// - fetch above internal top toggles strobe
// - external select toggles strobe on every fetch
// - high select: internal unless above top
// - low select: every fetch external
// - access select latched at reset
// - external clock accepted, oscillator output unused
// - port 2 high address or register contents
// - separate active-low read and write strobes
`timescale 1ns/1ps

module ems_strobes #(
    parameter logic [15:0] INT_TOP = ems_pkg::RST_TOP  // highest internal program address
) (
    input  wire logic              i_mclk,                  // oscillator clock
    input  wire logic              i_rst_n,                 // synchronous reset, active low
    input  wire logic              i_ce,                    // clock enable
    input  wire logic              i_ext_access_select_n,   // access select pin
    input  wire ems_pkg::ems_mode_t i_mode,                 // idle / power-down
    input  wire logic [15:0]       i_fetch_addr,            // program counter
    input  wire logic              i_quiet_wr,              // quiet bit write strobe
    input  wire logic              i_quiet_wdata,           // quiet bit write value
    input  wire logic              i_xreq_valid,            // data move request
    input  wire ems_pkg::ems_xreq_t i_xreq,                 // data move details
    input  wire logic [7:0]        i_high_address_port_register, // port 2 register
    input  wire logic [7:0]        i_p0_in,                 // port 0 pin levels
    output logic                   o_ale,                   // address latch strobe
    output logic                   o_program_fetch_strobe_n,// fetch read strobe
    output logic                   o_wr_n,                  // data write strobe
    output logic                   o_rd_n,                  // data read strobe
    output logic [7:0]             o_p0_out,                // port 0 drive value
    output logic                   o_p0_oe,                 // port 0 driven
    output logic [7:0]             o_p2_out,                // port 2 drive value
    output logic                   o_p2_oe,                 // port 2 owned by bus
    output logic                   o_oscillator_output,     // unused with external clock
    output logic                   o_quiet_strobe_bit,      // quiet bit readback
    output logic                   o_ea_latched_n,          // latched access select
    output logic                   o_xreq_busy,             // request held or data move running
    output logic                   o_xdata_done,            // data move finished pulse
    output logic [7:0]             o_xdata_rdata,           // read byte
    output logic                   o_instr_valid,           // instruction byte pulse
    output logic [7:0]             o_instr_byte             // fetched byte
);
    import ems_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    ems_phase_t  ph;            // oscillator period within machine cycle
    ems_cycle_t  kind;          // current machine cycle kind
    ems_xreq_t   xr;            // held data move request
    logic        xr_valid;      // request waiting for its cycle
    logic [15:0] cyc_addr;      // address of the current cycle
    logic        ea_s1;         // access select sync stage 1
    logic        ea_s2;         // access select sync stage 2
    logic [7:0]  p0_s1;         // port 0 sync stage 1
    logic [7:0]  p0_s2;         // port 0 sync stage 2
    logic        fs_d1;         // fetch strobe delayed to match sync
    logic        fs_d2;
    logic        rw_d1;         // data strobe delayed to match sync
    logic        rw_d2;
    logic        rd_d1;         // read strobe delayed to match sync
    logic        rd_d2;

    // ==========================================================
    // next phase and cycle decision
    // ==========================================================
    ems_phase_t next_ph;
    ems_cycle_t next_kind;
    wire        at_last   = (ph == PH_LAST);
    // fetch location
    // low select forces external; high select only above the top address
    wire        fetch_ext = !o_ea_latched_n || (i_fetch_addr > INT_TOP);
    wire        take_xr   = at_last && xr_valid && !i_mode.pdown;

    assign next_ph = at_last ? EMS_PH0 : ems_phase_t'(ph + 3'h1);

    // data move replaces fetch
    // a held data move wins the next cycle unless in power-down, so its fetch strobes never appear
    always_comb begin
        next_kind = kind;
        if (at_last) begin
            if (i_mode.pdown) begin
                next_kind = EMS_CY_PDOWN;
            end else if (xr_valid) begin
                next_kind = EMS_CY_XDATA;
            end else if (i_mode.idle) begin
                next_kind = EMS_CY_IDLE;
            end else if (fetch_ext) begin
                next_kind = EMS_CY_FETCH;
            end else begin
                next_kind = EMS_CY_INT;
            end
        end
    end

    // ==========================================================
    // pin values for the coming oscillator period
    // ==========================================================
    wire n_first = (next_ph == PH_FIRST);
    wire n_addr  = (next_ph <= PH_ADDR_LAST);
    wire n_rw    = (next_ph >= PH_STB_A) && (next_ph <= PH_STB_B);
    wire n_fetch = (next_kind == EMS_CY_FETCH);
    wire n_xd    = (next_kind == EMS_CY_XDATA);
    wire n_bus   = n_fetch || n_xd;
    wire quiet_n = o_quiet_strobe_bit;

    // latch strobe
    // bus cycles always pulse; internal cycles pulse unless quiet;
    // quiet idle stays high, quiet power-down stays low
    wire next_ale =
        n_bus ? n_first :
        (next_kind == EMS_CY_INT) ? (n_first && !quiet_n) :
        (next_kind == EMS_CY_IDLE) ? (quiet_n ? 1'b1 : n_first) :
        1'b0;

    // two fetch strobes
    // low in the strobe phases only; power-down never reaches here
    wire next_fs_n = !(n_fetch && ((next_ph == PH_STB_A) || (next_ph == PH_STB_B)));

    wire next_wr_n = !(n_xd && xr.wr && n_rw);
    wire next_rd_n = !(n_xd && !xr.wr && n_rw);

    // port 0 multiplex
    // address through the latch fall, then write data or released for reads
    wire [15:0] n_addr16 = n_xd ? xr.addr : (at_last ? i_fetch_addr : cyc_addr);
    wire        next_p0_oe  = (n_bus && n_addr) || (n_xd && xr.wr);
    wire [7:0]  next_p0_out = n_addr ? n_addr16[7:0] : xr.wdata;

    wire        next_p2_oe  = n_bus;
    wire [7:0]  next_p2_out = (n_xd && !xr.addr16) ? i_high_address_port_register
                                                   : n_addr16[15:8];

    // capture points: last low sample of a strobe, seen after the sync delay
    wire fs_end = fs_d2 && !fs_d1;
    wire rw_end = rw_d2 && !rw_d1;

    // ==========================================================
    // sequencer
    // ==========================================================
    // phase counter and cycle kind; reset starts a fresh machine cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ph   <= EMS_PH0;
            kind <= EMS_CY_IDLE;
        end else if (i_ce) begin
            ph   <= next_ph;
            kind <= next_kind;
        end
    end

    // address held for a whole fetch cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cyc_addr <= 16'h0000;
        end else if (i_ce && at_last) begin
            cyc_addr <= n_addr16;
        end
    end

    // quiet bit register
    // software may set or clear it at any time
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_quiet_strobe_bit <= RST_QUIET;
        end else if (i_ce && i_quiet_wr) begin
            o_quiet_strobe_bit <= i_quiet_wdata;
        end
    end

    // data move request holder; a new request is taken only when empty
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            xr_valid <= 1'b0;
            xr       <= '0;
        end else if (i_ce) begin
            if (take_xr) begin
                xr_valid <= 1'b0;
            end else if (i_xreq_valid && !xr_valid) begin
                xr_valid <= 1'b1;
                xr       <= i_xreq;
            end
        end
    end

    // busy covers the wait and the move itself
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_xreq_busy <= 1'b0;
        end else if (i_ce) begin
            o_xreq_busy <= xr_valid || (i_xreq_valid && !xr_valid) || n_xd;
        end
    end

    // ==========================================================
    // pins
    // ==========================================================
    // every pin comes from a flop; reset leaves the bus released
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_ale                    <= 1'b0;
            o_program_fetch_strobe_n <= 1'b1;
            o_wr_n                   <= 1'b1;
            o_rd_n                   <= 1'b1;
            o_p0_out                 <= RST_BYTE;
            o_p0_oe                  <= 1'b0;
            o_p2_out                 <= RST_BYTE;
            o_p2_oe                  <= 1'b0;
        end else if (i_ce) begin
            o_ale                    <= next_ale;
            o_program_fetch_strobe_n <= next_fs_n;
            o_wr_n                   <= next_wr_n;
            o_rd_n                   <= next_rd_n;
            o_p0_out                 <= next_p0_out;
            o_p0_oe                  <= next_p0_oe;
            o_p2_out                 <= next_p2_out;
            o_p2_oe                  <= next_p2_oe;
        end
    end

    // oscillator output
    // the clock arrives ready-made, so the amplifier output is parked low
    always_ff @(posedge i_mclk) begin
        o_oscillator_output <= 1'b0;
    end

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // stage 1 is read only by stage 2
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            p0_s1 <= RST_BYTE;
            p0_s2 <= RST_BYTE;
        end else if (i_ce) begin
            p0_s1 <= i_p0_in;
            p0_s2 <= p0_s1;
        end
    end

    // select pin keeps running through reset, else the latch only sees the reset value
    always_ff @(posedge i_mclk) begin
        if (i_ce) begin
            ea_s1 <= i_ext_access_select_n;
            ea_s2 <= ea_s1;
        end
    end

    // select latch
    // sampled while reset is held; a reset shorter than the sync depth
    // would latch a stale level, the two machine cycles cover it
    always_ff @(posedge i_mclk) begin
        if (i_ce && !i_rst_n) begin
            o_ea_latched_n <= ea_s2;
        end
    end

    // ==========================================================
    // read capture
    // ==========================================================
    // strobe copies delayed to line up with the port 0 sync stages
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            fs_d1 <= 1'b0;
            fs_d2 <= 1'b0;
            rw_d1 <= 1'b0;
            rw_d2 <= 1'b0;
            rd_d1 <= 1'b0;
            rd_d2 <= 1'b0;
        end else if (i_ce) begin
            fs_d1 <= !o_program_fetch_strobe_n;
            fs_d2 <= fs_d1;
            rw_d1 <= !(o_rd_n && o_wr_n);
            rw_d2 <= rw_d1;
            rd_d1 <= !o_rd_n;
            rd_d2 <= rd_d1;
        end
    end

    // byte capture
    // the memory holds the byte until its strobe rises; the last low sample wins
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_instr_valid <= 1'b0;
            o_instr_byte  <= RST_BYTE;
            o_xdata_done  <= 1'b0;
            o_xdata_rdata <= RST_BYTE;
        end else if (i_ce) begin
            o_instr_valid <= fs_end;
            o_xdata_done  <= rw_end;
            if (fs_end) begin
                o_instr_byte <= p0_s2;
            end
            if (rw_end && rd_d2) begin
                o_xdata_rdata <= p0_s2;
            end
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n || !i_ce);

    // latch strobe high only in the first period, except the quiet idle level
    property p_ale_phase;
        o_ale && !((kind == EMS_CY_IDLE) && $past(o_quiet_strobe_bit)) |-> (ph == EMS_PH0);
    endproperty
    a_ale_phase: assert property (p_ale_phase) else $error("latch strobe off phase");

    // bus cycle: strobe at phase 0 and address on port 0 through phase 1
    property p_addr_at_fall;
        (ph == EMS_PH0) && (kind == EMS_CY_FETCH || kind == EMS_CY_XDATA) |->
            o_ale && o_p0_oe ##1 !o_ale && o_p0_oe && $stable(o_p0_out);
    endproperty
    a_addr_at_fall: assert property (p_addr_at_fall) else $error("address not held");

    // read cycles keep port 0 released while the read strobe is low
    property p_p0_release;
        !o_rd_n |-> !o_p0_oe;
    endproperty
    a_p0_release: assert property (p_p0_release) else $error("port 0 contention");

    // fetch cycle: strobe low at periods 2 and 4, high at 3
    property p_two_fetch;
        (ph == EMS_PH1) && (kind == EMS_CY_FETCH) |->
            ##1 !o_program_fetch_strobe_n ##1 o_program_fetch_strobe_n
            ##1 !o_program_fetch_strobe_n ##1 o_program_fetch_strobe_n;
    endproperty
    a_two_fetch: assert property (p_two_fetch) else $error("fetch strobe count");

    // no fetch strobe inside a data move
    property p_skip_fetch;
        (kind == EMS_CY_XDATA) |-> o_program_fetch_strobe_n;
    endproperty
    a_skip_fetch: assert property (p_skip_fetch) else $error("fetch during move");

    // power-down: fetch strobe high and quiet latch strobe low
    property p_pdown;
        (kind == EMS_CY_PDOWN) |-> o_program_fetch_strobe_n && !o_ale;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down pins");

    // quiet internal cycles never raise the latch strobe
    property p_quiet_int;
        (kind == EMS_CY_INT) && o_quiet_strobe_bit && $stable(o_quiet_strobe_bit) |-> !o_ale;
    endproperty
    a_quiet_int: assert property (p_quiet_int) else $error("quiet strobe toggled");

    // quiet idle holds the strobe high
    property p_quiet_idle;
        (kind == EMS_CY_IDLE) && $past(o_quiet_strobe_bit) |-> o_ale;
    endproperty
    a_quiet_idle: assert property (p_quiet_idle) else $error("quiet idle not high");

    // quiet bit follows a write one cycle later
    property p_quiet_wr;
        i_quiet_wr |=> (o_quiet_strobe_bit == $past(i_quiet_wdata));
    endproperty
    a_quiet_wr: assert property (p_quiet_wr) else $error("quiet bit write lost");

    // a held request becomes a data move within one machine cycle
    property p_xd_start;
        xr_valid && !i_mode.pdown |-> ##[1:6] (kind == EMS_CY_XDATA);
    endproperty
    a_xd_start: assert property (p_xd_start) else $error("data move not started");

    // low select forces every fetch cycle external
    property p_ea_low;
        !o_ea_latched_n && (kind == EMS_CY_INT) |-> 1'b0;
    endproperty
    a_ea_low: assert property (p_ea_low) else $error("internal fetch with low select");

    // a read move ends with a done pulse carrying the byte
    property p_rd_done;
        $rose(o_rd_n) |-> ##2 o_xdata_done;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read not completed");

    c_fetch:   cover property ((kind == EMS_CY_FETCH) && o_instr_valid);
    c_xd_rd:   cover property ((kind == EMS_CY_XDATA) && !o_rd_n);
    c_xd_wr:   cover property ((kind == EMS_CY_XDATA) && !o_wr_n);
    c_quiet:   cover property (o_quiet_strobe_bit && (kind == EMS_CY_INT));

endmodule

/* File: ems_pkg.sv */
// ems_pkg: shared constants and types for the external memory strobe block.
// assumes one oscillator clock; six oscillator periods form one machine cycle.
package ems_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int unsigned CLK_HZ        = 40000000;  // oscillator rate
    localparam int unsigned OSC_PER_MC    = 6;         // oscillator periods per machine cycle
    localparam int unsigned SYNC_STAGES   = 2;         // pin synchroniser depth

    // ==========================================================
    // phase positions inside a machine cycle
    // ==========================================================
    localparam logic [2:0]  PH_FIRST      = 3'h0;      // address latch strobe high
    localparam logic [2:0]  PH_ADDR_LAST  = 3'h1;      // low address still driven
    localparam logic [2:0]  PH_STB_A      = 3'h2;      // first fetch strobe / rw start
    localparam logic [2:0]  PH_STB_B      = 3'h4;      // second fetch strobe / rw end
    localparam logic [2:0]  PH_LAST       = 3'h5;      // next cycle is decided here

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic        RST_QUIET     = 1'b0;      // quiet strobe bit after reset
    localparam logic        RST_EA_N      = 1'b1;      // latched access select default
    localparam logic [7:0]  RST_BYTE      = 8'h00;     // byte registers after reset
    localparam logic [15:0] RST_TOP       = 16'h1FFF;  // default top internal address

    // ==========================================================
    // types
    // ==========================================================
    // phase of the machine cycle, one state per oscillator period
    typedef enum logic [2:0] {
        EMS_PH0 = 3'b000,
        EMS_PH1 = 3'b001,
        EMS_PH2 = 3'b010,
        EMS_PH3 = 3'b011,
        EMS_PH4 = 3'b100,
        EMS_PH5 = 3'b101
    } ems_phase_t;

    // what the current machine cycle does on the pins
    typedef enum logic [2:0] {
        EMS_CY_IDLE  = 3'b000,   // idle mode, no fetch
        EMS_CY_INT   = 3'b001,   // internal fetch
        EMS_CY_FETCH = 3'b010,   // external program fetch
        EMS_CY_XDATA = 3'b011,   // external data move
        EMS_CY_PDOWN = 3'b100    // power-down
    } ems_cycle_t;

    // external data move request from the core
    typedef struct packed {
        logic        wr;         // 1 write, 0 read
        logic        addr16;     // 1 sixteen-bit address, 0 eight-bit indirect
        logic [15:0] addr;       // data address
        logic [7:0]  wdata;      // write byte
    } ems_xreq_t;

    // core operating mode
    typedef struct packed {
        logic        idle;       // idle mode
        logic        pdown;      // power-down mode
    } ems_mode_t;

endpackage

/* File: ems_ext_mem.sv */
// ems_ext_mem: external memory and address latch facing ems_strobes.
// assumes the pin levels of port 0 and the strobes, all on i_mclk.
`timescale 1ns/1ps
module ems_ext_mem (
    input  wire logic       i_mclk,
    input  wire logic       i_ale,
    input  wire logic       i_fetch_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic [7:0] i_p0,
    input  wire logic       i_p0_oe,
    output logic      [7:0] o_p0
);
    // ====================
    // storage
    // ====================
    logic [7:0] mem [256];  // preset to address xor 5A
    logic [7:0] lat;        // latched low address
    logic [7:0] last;       // last byte driven
    logic       ale_q;      // delayed strobe, finds its fall
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
        lat = 8'h00;
        last = 8'h00;
        ale_q = 1'b0;
    end
    always @(posedge i_mclk) begin
        ale_q <= i_ale;
        if (ale_q && !i_ale) begin
            lat <= i_p0;
        end
        if (!i_wr_n && i_p0_oe) begin
            mem[lat] <= i_p0;
        end
        if (!i_fetch_n || !i_rd_n) begin
            last <= mem[lat];
        end
    end
    // drive while a strobe is low; inverse once released, so stale data never passes
    assign o_p0 = (!i_fetch_n || !i_rd_n) ? mem[lat] : ~last;
endmodule

/* File: ems_strobes_bench.sv */
// ems_strobes_bench: self-checking bench of the external memory strobes.
// assumes ems_pkg, ems_strobes and ems_ext_mem are compiled before it.
`timescale 1ns/1ps
module ems_strobes_bench;
    import ems_pkg::*;
    // ====================
    // signals
    // ====================
    logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_ext_access_select_n = 1'b0;
    logic        i_quiet_wr = 1'b0, i_quiet_wdata = 1'b0, i_xreq_valid = 1'b0, chk_ib = 1'b0;
    ems_mode_t   i_mode = '0;
    ems_xreq_t   i_xreq = '0;
    logic [15:0] i_fetch_addr = 16'h0123;
    logic [7:0]  i_high_address_port_register = 8'h00, mem_p0, p2_seen, exp_byte;
    wire  [7:0]  i_p0_in;
    logic        o_ale, o_program_fetch_strobe_n, o_wr_n, o_rd_n, o_p0_oe, o_p2_oe;
    logic        o_quiet_strobe_bit, o_ea_latched_n, o_xreq_busy, o_xdata_done, o_instr_valid;
    logic [7:0]  o_p0_out, o_p2_out, o_xdata_rdata, o_instr_byte;
    int          fail_count = 0, checks = 0, n_ale, n_fs, n_hi;
    // pin level: the device wins while it drives
    assign i_p0_in = o_p0_oe ? o_p0_out : mem_p0;
    ems_strobes i_dut (.i_mclk, .i_rst_n, .i_ce(1'b1), .i_ext_access_select_n, .i_mode,
        .i_fetch_addr, .i_quiet_wr, .i_quiet_wdata, .i_xreq_valid, .i_xreq,
        .i_high_address_port_register, .i_p0_in, .o_ale, .o_program_fetch_strobe_n, .o_wr_n,
        .o_rd_n, .o_p0_out, .o_p0_oe, .o_p2_out, .o_p2_oe, .o_oscillator_output(),
        .o_quiet_strobe_bit, .o_ea_latched_n, .o_xreq_busy, .o_xdata_done, .o_xdata_rdata,
        .o_instr_valid, .o_instr_byte);
    ems_ext_mem i_mem (.i_mclk, .i_ale(o_ale), .i_fetch_n(o_program_fetch_strobe_n),
        .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_p0(i_p0_in), .i_p0_oe(o_p0_oe), .o_p0(mem_p0));
    initial forever #12.5 i_mclk = ~i_mclk;
    // port 2 as seen while a data strobe is low
    always @(posedge i_mclk) if (!o_wr_n || !o_rd_n) p2_seen <= o_p2_out;
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // count strobe edges and latch-high clocks over n clocks
    task automatic span(input int n);
        logic a0, f0;
        a0 = o_ale;
        f0 = o_program_fetch_strobe_n;
        n_ale = 0;
        n_fs = 0;
        n_hi = 0;
        repeat (n) begin
            @(posedge i_mclk);
            #1;
            n_ale += int'(o_ale === 1'b1 && a0 === 1'b0);
            n_fs += int'(o_program_fetch_strobe_n === 1'b0 && f0 === 1'b1);
            n_hi += int'(o_ale === 1'b1);
            if (chk_ib && o_instr_valid === 1'b1) chk(o_instr_byte === exp_byte, "fetch byte");
            a0 = o_ale;
            f0 = o_program_fetch_strobe_n;
        end
    endtask
    task automatic setq(input logic v);
        @(negedge i_mclk);
        i_quiet_wr = 1'b1;
        i_quiet_wdata = v;
        @(negedge i_mclk);
        i_quiet_wr = 1'b0;
    endtask
    task automatic rst(input logic ea);
        @(negedge i_mclk);
        i_rst_n = 1'b0;
        i_ext_access_select_n = ea;
        repeat (16) @(negedge i_mclk);
        i_rst_n = 1'b1;
    endtask
    task automatic xmove(input logic wr, a16, input logic [15:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_xreq = '{wr: wr, addr16: a16, addr: a, wdata: d};
        i_xreq_valid = 1'b1;
        @(negedge i_mclk);
        i_xreq_valid = 1'b0;
        chk(o_xreq_busy === 1'b1, "busy not raised");
        repeat (40) begin
            @(posedge i_mclk);
            #1;
            if (o_xdata_done === 1'b1) return;
        end
        chk(1'b0, "move never finished");
    endtask
    initial begin
        rst(1'b0);
        chk(o_quiet_strobe_bit === 1'b0 && o_program_fetch_strobe_n === 1'b1, "reset");
        exp_byte = 8'h23 ^ 8'h5A;
        chk_ib = 1'b1;
        span(12);
        span(60);
        chk(n_ale == 10, "latch strobe rate");
        chk(n_fs == 20, "fetch strobe count");
        chk(i_mem.lat === 8'h23, "latched address");
        setq(1'b1);
        span(60);
        chk(n_ale == 10 && o_quiet_strobe_bit === 1'b1, "quiet, external");
        fork
            xmove(1'b1, 1'b1, 16'h3C42, 8'hC3);
            span(60);
        join
        chk(n_fs == 18, "fetch skipped for move");
        chk(i_mem.mem[8'h42] === 8'hC3 && p2_seen === 8'h3C, "write move");
        @(negedge i_mclk);
        i_high_address_port_register = 8'h77;
        xmove(1'b0, 1'b0, 16'h0055, 8'h00);
        chk(o_xdata_rdata === 8'h0F && p2_seen === 8'h77, "read move");
        setq(1'b0);
        chk(o_quiet_strobe_bit === 1'b0, "quiet clear");
        chk_ib = 1'b0;
        i_fetch_addr = 16'h0100;
        rst(1'b1);
        i_ext_access_select_n = 1'b0;
        setq(1'b1);
        span(12);
        span(60);
        chk(n_hi == 0 && n_fs == 0 && o_ea_latched_n === 1'b1, "quiet internal");
        fork
            xmove(1'b0, 1'b1, 16'h0011, 8'h00);
            span(60);
        join
        chk(n_ale == 1, "move in quiet");
        @(negedge i_mclk);
        i_fetch_addr = 16'h2000;
        exp_byte = 8'h5A;
        chk_ib = 1'b1;
        span(12);
        span(60);
        chk(n_ale == 10 && n_fs == 20, "fetch above top");
        @(negedge i_mclk);
        i_fetch_addr = 16'h0100;
        i_mode = '{idle: 1'b1, pdown: 1'b0};
        chk_ib = 1'b0;
        span(12);
        span(60);
        chk(n_hi == 60 && n_fs == 0, "quiet idle");
        @(negedge i_mclk);
        i_mode = '{idle: 1'b0, pdown: 1'b1};
        span(12);
        span(60);
        chk(n_hi == 0 && n_fs == 0, "quiet power-down");
        complete_run();
    end
    // watchdog well past the planned span of about 600 clocks
    initial begin
        repeat (5000) @(posedge i_mclk);
        fail_count++;
        complete_run();
    end
endmodule
